// *** rtl/seq_ctl_params.svh ***
`ifndef SEQ_CTL_PARAMS_SVH
`define SEQ_CTL_PARAMS_SVH
// byte addresses on the register bus
`define CSR_OFFSET        4'h0
`define IRQ_STAT_OFFSET   4'h4
`define IRQ_MASK_OFFSET   4'h8
`define LIMIT_OFFSET      4'hc
// control/status field positions
`define BIT_ENABLE        15
`define BIT_STOP_IDLE     13
`define BIT_TOGGLE        12
`define BIT_SW_TRIG       10
`define BIT_SINGLE_STEP   9
`define BIT_VISIBILITY    8
`define BIT_START         7
`define BIT_WDT_FLAG      6
`define FIELD_INMODE_HI   1
`define FIELD_INMODE_LO   0
// writable bits of the control/status word
`define CSR_WMASK         16'hb783
`define CSR_RESET         16'h0000
// interrupt status bits
`define IRQ_BIT_WDT       0
`define IRQ_BIT_SWTRIG    1
`define IRQ_RESET         2'h0
`endif

// *** rtl/seq_ctl_pkg.sv ***
package seq_ctl_pkg;
  typedef struct packed {
    logic       enable;
    logic       stop_in_idle;
    logic       toggle_mode;
    logic       single_step;
    logic       visibility;
    logic       start;
    logic       wdt_flag;
    logic [1:0] input_mode;
  } ctl_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;

  typedef struct packed {
    logic [1:0]  rst_sync;
    bus_state_t  bus;
    ctl_t        ctl;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [15:0] limit_shadow;
    logic [15:0] rdata;
    logic        sw_trig;
  } state_t;
endpackage

// *** rtl/trigger_sequencer_control_status.sv ***
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "seq_ctl_params.svh"
// What this block does
// RULE1: enable bit 15 runs the sequencer
// RULE2: bit 13 halts sequencer during idle
// RULE3: bit 12 set: trigger command toggles output
// RULE4: bit 12 clear: trigger command emits pulse
// RULE5: writing one to bit 10 triggers
// RULE6: bit 9 enables single-step mode
// RULE7: bit 8 set: limit reads show live
// RULE8: bit 8 clear: limit reads show written
// RULE9: bit 7 starts continuous command execution
// RULE10: hardware sets bit 6 on watchdog timeout
// RULE11: bits 1:0 steer wait-input commands only
// RULE12: bits 14,11,5:2 read zero, ignore writes
// RULE13: software trigger is one-cycle pulse
module trigger_sequencer_control_status #(
  parameter int LIMIT_W = 16
) (
  input  wire logic               mclk_i,
  input  wire logic               nrst_i,
  input  wire logic [3:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  input  wire logic [3:0]         avs_byteenable_i,
  output logic      [31:0]        avs_readdata_o,
  output logic                    avs_waitrequest_o,
  input  wire logic               device_idle_i,
  input  wire logic               wdt_timeout_i,
  input  wire logic [LIMIT_W-1:0] live_count_i,
  output logic                    seq_run_o,
  output logic                    toggle_mode_o,
  output logic                    single_step_o,
  output logic                    start_o,
  output logic [1:0]              input_mode_o,
  output logic                    sw_trigger_o,
  output logic [LIMIT_W-1:0]      limit_value_o,
  output logic                    limit_write_o,
  output logic                    irq_o
);
  seq_ctl_pkg::state_t st_r;
  seq_ctl_pkg::state_t st_nxt;
  logic [1:0]          idle_sync_r;
  logic                rst_n;
  logic [15:0]         csr_view;
  logic [15:0]         wdata16;
  logic                acc;
  logic                wr;
  logic [1:0]          events;

  assign rst_n = st_r.rst_sync[1];
  assign wdata16 = avs_writedata_i[15:0];
  assign acc = (avs_read_i | avs_write_i) && st_r.bus == seq_ctl_pkg::BUS_IDLE;
  // write commits on the edge that ends the wait state, as the master sees it
  assign wr = avs_write_i && st_r.bus == seq_ctl_pkg::BUS_ACK
              && (&avs_byteenable_i[1:0]);

  always_comb begin
    csr_view = 16'h0000; // RULE12
    csr_view[`BIT_ENABLE]      = st_r.ctl.enable;
    csr_view[`BIT_STOP_IDLE]   = st_r.ctl.stop_in_idle;
    csr_view[`BIT_TOGGLE]      = st_r.ctl.toggle_mode;
    csr_view[`BIT_SINGLE_STEP] = st_r.ctl.single_step;
    csr_view[`BIT_VISIBILITY]  = st_r.ctl.visibility;
    csr_view[`BIT_START]       = st_r.ctl.start;
    csr_view[`BIT_WDT_FLAG]    = st_r.ctl.wdt_flag;
    csr_view[`FIELD_INMODE_HI:`FIELD_INMODE_LO] = st_r.ctl.input_mode;
  end

  // device_idle_i is synchronised over two flops; the struct keeps its own reset flops
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_sync_r <= 2'h0;
    end else begin
      idle_sync_r <= {idle_sync_r[0], device_idle_i};
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_sync = {st_r.rst_sync[0], 1'b1};
    st_nxt.sw_trig = 1'b0;
    events = 2'h0;
    events[`IRQ_BIT_WDT] = wdt_timeout_i & ~st_r.ctl.wdt_flag;
    if (acc) begin
      st_nxt.bus = seq_ctl_pkg::BUS_ACK;
      // read data stands until the next read; writes leave it alone
      if (avs_read_i) begin
        case (avs_address_i)
          `CSR_OFFSET:      st_nxt.rdata = csr_view;
          `IRQ_STAT_OFFSET: st_nxt.rdata = {14'h0000, st_r.irq_stat};
          `IRQ_MASK_OFFSET: st_nxt.rdata = {14'h0000, st_r.irq_mask};
          `LIMIT_OFFSET: begin
            if (st_r.ctl.visibility) begin
              st_nxt.rdata = 16'(live_count_i); // RULE7
            end else begin
              st_nxt.rdata = st_r.limit_shadow; // RULE8
            end
          end
          default:          st_nxt.rdata = 16'h0000;
        endcase
      end
    end else begin
      st_nxt.bus = seq_ctl_pkg::BUS_IDLE;
    end
    if (wr) begin
      case (avs_address_i)
        `CSR_OFFSET: begin
          st_nxt.ctl.enable       = wdata16[`BIT_ENABLE]; // RULE1
          st_nxt.ctl.stop_in_idle = wdata16[`BIT_STOP_IDLE]; // RULE2
          st_nxt.ctl.toggle_mode  = wdata16[`BIT_TOGGLE];
          st_nxt.ctl.single_step  = wdata16[`BIT_SINGLE_STEP]; // RULE6
          st_nxt.ctl.visibility   = wdata16[`BIT_VISIBILITY];
          st_nxt.ctl.start        = wdata16[`BIT_START]; // RULE9
          st_nxt.ctl.input_mode   =
            wdata16[`FIELD_INMODE_HI:`FIELD_INMODE_LO]; // RULE11
          // flag is hardware-set only; software may clear it by writing 0
          if (!wdata16[`BIT_WDT_FLAG]) begin
            st_nxt.ctl.wdt_flag = 1'b0;
          end
          if (wdata16[`BIT_SW_TRIG]) begin
            st_nxt.sw_trig = 1'b1; // RULE5 RULE13
            events[`IRQ_BIT_SWTRIG] = 1'b1;
          end
        end
        `IRQ_STAT_OFFSET: begin
          st_nxt.irq_stat = st_r.irq_stat & ~wdata16[1:0];
        end
        `IRQ_MASK_OFFSET: st_nxt.irq_mask = wdata16[1:0];
        `LIMIT_OFFSET:    st_nxt.limit_shadow = wdata16;
        default: ;
      endcase
    end
    // hardware set wins over a same-cycle software clear
    if (wdt_timeout_i) begin
      st_nxt.ctl.wdt_flag = 1'b1; // RULE10
    end
    st_nxt.irq_stat = st_nxt.irq_stat | events;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else if (!rst_n) begin
      st_r          <= '0;
      st_r.rst_sync <= {st_r.rst_sync[0], 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i)
                           && st_r.bus == seq_ctl_pkg::BUS_IDLE;
  assign avs_readdata_o    = {16'h0000, st_r.rdata};
  // stop-in-idle freezes the core while the device idles
  assign seq_run_o     = st_r.ctl.enable
                       & ~(st_r.ctl.stop_in_idle & idle_sync_r[1]); // RULE1 RULE2
  assign toggle_mode_o = st_r.ctl.toggle_mode; // RULE3 RULE4
  assign single_step_o = st_r.ctl.single_step;
  assign start_o       = st_r.ctl.start & seq_run_o; // RULE9
  assign input_mode_o  = st_r.ctl.input_mode;
  assign sw_trigger_o  = st_r.sw_trig; // RULE13
  assign limit_value_o = LIMIT_W'(st_r.limit_shadow);
  assign limit_write_o = 1'b0;
  assign irq_o         = |(st_r.irq_stat & st_r.irq_mask);
endmodule

// *** verif/seq_ctl_monitor.sv ***
`timescale 1ns/1ps
module seq_ctl_monitor #(
  parameter int LIMIT_W = 16
) (
  input wire logic               mclk_i,
  input wire logic               nrst_i,
  input wire logic [3:0]         avs_address_i,
  input wire logic               avs_read_i,
  input wire logic               avs_write_i,
  input wire logic [31:0]        avs_writedata_i,
  input wire logic [31:0]        avs_readdata_o,
  input wire logic               avs_waitrequest_o,
  input wire logic               seq_run_o,
  input wire logic               toggle_mode_o,
  input wire logic               start_o,
  input wire logic               sw_trigger_o,
  input wire logic [LIMIT_W-1:0] limit_value_o
);
  wire csr_wr = avs_write_i && avs_address_i == 4'h0;
  wire lim_wr = avs_write_i && avs_address_i == 4'hc;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_start_needs_run: assert property (start_o |-> seq_run_o)
    else $error("start without run");
  a_swtrig_single: assert property (sw_trigger_o |=> !sw_trigger_o)
    else $error("trigger longer than one cycle");
  a_swtrig_cause: assert property (sw_trigger_o |->
    $past(csr_wr && !avs_waitrequest_o && avs_writedata_i[10]))
    else $error("trigger without write");
  a_one_wait: assert property ($rose(avs_read_i) |->
    avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("wait state count wrong");
  a_unimpl_zero: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i == 4'h0 |=> (avs_readdata_o & 32'hffff4c3c) == 0)
    else $error("unimplemented bits set");
  a_toggle_by_write: assert property ($changed(toggle_mode_o) |->
    $past(csr_wr) || $past(csr_wr, 2))
    else $error("toggle mode changed alone");
  a_limit_by_write: assert property ($changed(limit_value_o) |->
    $past(lim_wr) || $past(lim_wr, 2))
    else $error("limit changed alone");
  a_read_stands: assert property (!avs_read_i |=>
    $stable(avs_readdata_o))
    else $error("read data moved");
  c_swtrig: cover property (sw_trigger_o);
  c_start: cover property (start_o);
  c_toggle: cover property ($rose(toggle_mode_o));
endmodule
bind trigger_sequencer_control_status seq_ctl_monitor #(.LIMIT_W(LIMIT_W))
  i_mon (.mclk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .seq_run_o,
  .toggle_mode_o, .start_o, .sw_trigger_o, .limit_value_o);

// *** verif/trigger_sequencer_control_status_tb_top.sv ***
`timescale 1ns/1ps
module trigger_sequencer_control_status_tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic        idle = 1'b0, wdt = 1'b0, wreq, run, tgl, sst, strt, swt, irq;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] live = 16'h5555, lim, d;
  logic [1:0]  imode;
  int          errors = 0, total_checks = 0, cycles = 0, pulses = 0;
  trigger_sequencer_control_status #(.LIMIT_W(16)) i_dut (.mclk_i(clk),
    .nrst_i(rst_n), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .device_idle_i(idle), .wdt_timeout_i(wdt),
    .live_count_i(live), .seq_run_o(run), .toggle_mode_o(tgl),
    .single_step_o(sst), .start_o(strt), .input_mode_o(imode),
    .sw_trigger_o(swt), .limit_value_o(lim), .limit_write_o(), .irq_o(irq));
  initial forever #12.5 clk = ~clk;
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // run is under a hundred cycles; ceiling only catches a stuck handshake
  always @(posedge clk) begin
    cycles++;
    if (swt) pulses++;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
    do @(posedge clk); while (wreq !== 1'b0);
    d = rdata[15:0];
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    acc(0, 4'h0, 0); chk("csr_reset", 16'h0, d);
    acc(0, 4'h4, 0); chk("irq_reset", 16'h0, d);
    acc(1, 4'h0, 32'hffff); chk("sw_pulse", 1, pulses);
    acc(0, 4'h0, 0); chk("csr_rw", 16'hb383, d);
    chk("outs", 6'h3f, {run, strt, tgl, sst, imode});
    @(posedge clk) idle <= 1'b1;
    repeat (5) @(negedge clk);
    chk("idle_stop", 2'b00, {run, strt});
    acc(1, 4'h0, 32'h8080); chk("idle_run", 3'b110, {run, strt, tgl});
    acc(1, 4'h0, 0); chk("off", 2'b00, {run, strt});
    chk("sw_zero", 1, pulses);
    @(posedge clk) wdt <= 1'b1;
    @(posedge clk) wdt <= 1'b0;
    acc(0, 4'h0, 0); chk("wdt_flag", 16'h0040, d);
    chk("irq_masked", 1'b0, irq);
    acc(1, 4'h8, 32'h3); chk("irq_on", 1'b1, irq);
    acc(0, 4'h4, 0); chk("irq_stat", 16'h3, d);
    acc(1, 4'h4, 32'h3); chk("irq_clr", 1'b0, irq);
    acc(1, 4'h0, 0); acc(0, 4'h0, 0); chk("wdt_clr", 16'h0, d);
    acc(1, 4'hc, 32'h1234); acc(0, 4'hc, 0); chk("lim_wr", 16'h1234, d);
    chk("lim_out", 16'h1234, lim);
    acc(1, 4'h0, 32'h0100); acc(0, 4'hc, 0); chk("lim_live", 16'h5555, d);
    acc(0, 4'h2, 0); chk("unmapped", 16'h0, d);
    tally_and_finish();
  end
endmodule
